// ==== rtl/ebra_regs.vh ====
/*
 constants of the external bus ready and hold arbitration block: register
 offsets, control field positions, reset values and state codes.
 assumes inclusion by bare name from the design files of this block.
*/
// Overview of operation
// - at ready sampling, ready high adds a wait state, low ends the cycle
// - multiplexed mode adds a turnaround state, optionally a tri-state state
// - command leading edge is one state later when command delay is on
// - programmed memory wait states run before ready sampling starts
// - a running bus cycle finishes before the bus is granted away
// - on release, chip selects, address, data, ale and command outputs are floated; the clock output keeps running
// - regain request is never asserted before the bus is released
// - taking the bus back starts only when hold request goes high
// - hold may drop unasked; the bus is regained the same way
`ifndef EBRA_REGS_VH
`define EBRA_REGS_VH

// register offsets
`define EBRA_ADDR_W         4
`define EBRA_OFS_CTRL       4'h0
`define EBRA_OFS_STAT       4'h4
`define EBRA_OFS_RDATA      4'h8

// control register fields
`define EBRA_CTRL_W         10
`define EBRA_CTRL_RST       10'h000
`define EBRA_CTRL_MUX       0
`define EBRA_CTRL_TRI       1
`define EBRA_CTRL_CMDDLY    2
`define EBRA_CTRL_RDYEN     3
`define EBRA_CTRL_WS_LO     4
`define EBRA_CTRL_WS_HI     7
`define EBRA_CTRL_REGAIN    8
`define EBRA_CTRL_CKOEN     9

// status register fields
`define EBRA_STAT_GRANT     0
`define EBRA_STAT_BUSY      1
`define EBRA_STAT_BUS_REGAIN_REQUEST_OUT      2
`define EBRA_STAT_HOLD      3
`define EBRA_STAT_ST_LO     8

// one-hot bus states
`define EBRA_NST            9
`define EBRA_S_IDLE         9'h001
`define EBRA_S_ADDR         9'h002
`define EBRA_S_DLY          9'h004
`define EBRA_S_CMD          9'h008
`define EBRA_S_RDY          9'h010
`define EBRA_S_MUX          9'h020
`define EBRA_S_TRI          9'h040
`define EBRA_S_HOLD         9'h080
`define EBRA_S_REGN         9'h100

`endif

// ==== rtl/ebra_sync.v ====
/*
 two flip-flop synchroniser for the active-low ready input.
 assumes one clock; the input may change at any time.
*/
`timescale 1ns/100ps
module ebra_sync #(
   parameter RST_VAL = 1'b1
) (
   input  wire sys_clk,
   input  wire resetn,
   input  wire async_i,
   output wire sync_o
);
   reg meta_q;
   reg sync_q;

   // ==========================================================
   // first stage feeds only the second
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule

// ==== rtl/ebra_core.v ====
/*
 external bus cycle engine with ready wait states and hold/acknowledge
 arbitration, plus a small register port for configuration and status.
 assumes synchronous inputs except ready_n, pull-ups on the chip selects
 and an outside master that keeps its own timing on hold.
*/
`timescale 1ns/100ps
`include "ebra_regs.vh"
module ebra_core #(
   parameter AW = 24,
   parameter DW = 16,
   parameter NCS = 5
) (
   input  wire                   sys_clk,
   input  wire                   resetn,
   // register port
   input  wire [`EBRA_ADDR_W-1:0] reg_addr,
   input  wire [31:0]            reg_wdata,
   input  wire                   reg_wr,
   input  wire                   reg_rd,
   output wire [31:0]            reg_rdata,
   // cpu side request
   input  wire                   cpu_req,
   input  wire                   cpu_write,
   input  wire [AW-1:0]          cpu_addr,
   input  wire [2:0]             cpu_cs_sel,
   input  wire [DW-1:0]          cpu_wdata,
   output wire                   cpu_done,
   output wire [DW-1:0]          cpu_rdata,
   // external bus pins
   output wire                   system_clock_output,
   output wire [AW-1:0]          bus_addr_o,
   output wire                   bus_addr_oe,
   input  wire [DW-1:0]          bus_data_i,
   output wire [DW-1:0]          bus_data_o,
   output wire                   bus_data_oe,
   output wire                   ale_o,
   output wire                   ale_oe,
   output wire                   rd_n_o,
   output wire                   wr_n_o,
   output wire                   cmd_oe,
   output wire [NCS-1:0]         chip_select_lines_n_o,
   output wire                   chip_select_lines_oe,
   input  wire                   ready_n,
   input  wire                   hold_n,
   output wire                   bus_grant_ack_out_n,
   output wire                   bus_regain_request_out_n
);
   localparam [`EBRA_NST-1:0] S_IDLE = `EBRA_S_IDLE;
   localparam [`EBRA_NST-1:0] S_ADDR = `EBRA_S_ADDR;
   localparam [`EBRA_NST-1:0] S_DLY  = `EBRA_S_DLY;
   localparam [`EBRA_NST-1:0] S_CMD  = `EBRA_S_CMD;
   localparam [`EBRA_NST-1:0] S_RDY  = `EBRA_S_RDY;
   localparam [`EBRA_NST-1:0] S_MUX  = `EBRA_S_MUX;
   localparam [`EBRA_NST-1:0] S_TRI  = `EBRA_S_TRI;
   localparam [`EBRA_NST-1:0] S_HOLD = `EBRA_S_HOLD;
   localparam [`EBRA_NST-1:0] S_REGN = `EBRA_S_REGN;
   localparam WSW = `EBRA_CTRL_WS_HI - `EBRA_CTRL_WS_LO + 1;

   reg  [`EBRA_NST-1:0]    state_q, state_d;
   reg  [WSW-1:0]          ws_cnt_q, ws_cnt_d;
   reg  [`EBRA_CTRL_W-1:0] ctrl_q;
   reg  [31:0]             rdata_q;
   reg  [DW-1:0]           cpu_rdata_q;
   reg                     done_q;
   reg                     hold_q;
   reg                     clk_div_q;
   reg                     write_q;
   reg  [AW-1:0]           addr_q;
   reg  [DW-1:0]           wdata_q;
   reg  [NCS-1:0]          cs_n_q;
   wire                    ready_sync_n;
   wire                    cycle_end;
   wire                    bus_regain_request_out;
   wire [31:0]             stat_word;
   wire                    driving;
   wire                    cmd_on;

   // ==========================================================
   // ready synchroniser
   ebra_sync #(
      .RST_VAL (1'b1)
   ) u_rdy_sync (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .async_i (ready_n),
      .sync_o  (ready_sync_n)
   );

   // one-cold (active-low) select of a chip select line
   function [NCS-1:0] cs_decode;
      input [2:0] sel;
      integer i;
      begin
         cs_decode = {NCS{1'b1}};
         for (i = 0; i < NCS; i = i + 1) begin
            if (sel == i[2:0]) begin
               cs_decode[i] = 1'b0;
            end
         end
      end
   endfunction

   // ==========================================================
   // hold sampling and clock output divider
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         hold_q    <= 1'b1;
         clk_div_q <= 1'b0;
      end else begin
         hold_q    <= hold_n;
         clk_div_q <= ctrl_q[`EBRA_CTRL_CKOEN] ? ~clk_div_q : 1'b0;
      end
   end

   // ready sampled low (or ignored) ends the cycle, high adds a wait
   assign cycle_end = ~ctrl_q[`EBRA_CTRL_RDYEN] | ~ready_sync_n;

   // ==========================================================
   // bus state machine
   always @* begin
      state_d  = state_q;
      ws_cnt_d = ws_cnt_q;
      case (state_q)
         S_IDLE: begin
            if (!hold_q) begin
               state_d = S_HOLD;
            end else if (cpu_req) begin
               state_d = S_ADDR;
            end
         end
         S_ADDR: begin
            ws_cnt_d = ctrl_q[`EBRA_CTRL_WS_HI:`EBRA_CTRL_WS_LO];
            state_d  = ctrl_q[`EBRA_CTRL_CMDDLY] ? S_DLY : S_CMD;
         end
         S_DLY: begin
            state_d = S_CMD;
         end
         S_CMD: begin
            if (ws_cnt_q != {WSW{1'b0}}) begin
               ws_cnt_d = ws_cnt_q - 1'b1;
            end else begin
               state_d = S_RDY;
            end
         end
         S_RDY: begin
            if (cycle_end) begin
               if (ctrl_q[`EBRA_CTRL_MUX]) begin
                  state_d = S_MUX;
               end else if (ctrl_q[`EBRA_CTRL_TRI]) begin
                  state_d = S_TRI;
               end else begin
                  state_d = S_IDLE;
               end
            end
         end
         S_MUX: begin
            state_d = ctrl_q[`EBRA_CTRL_TRI] ? S_TRI : S_IDLE;
         end
         S_TRI: begin
            state_d = S_IDLE;
         end
         S_HOLD: begin
            if (hold_q) begin
               state_d = S_REGN;
            end
         end
         S_REGN: begin
            state_d = S_IDLE;
         end
         default: begin
            state_d = S_IDLE;
         end
      endcase
   end

   // ==========================================================
   // state, cycle latches and cpu answer
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_q     <= S_IDLE;
         ws_cnt_q    <= {WSW{1'b0}};
         done_q      <= 1'b0;
         cpu_rdata_q <= {DW{1'b0}};
         write_q     <= 1'b0;
         addr_q      <= {AW{1'b0}};
         wdata_q     <= {DW{1'b0}};
         cs_n_q      <= {NCS{1'b1}};
      end else begin
         state_q  <= state_d;
         ws_cnt_q <= ws_cnt_d;
         done_q   <= (state_q == S_RDY) && cycle_end;
         if (state_q == S_IDLE && state_d == S_ADDR) begin
            write_q <= cpu_write;
            addr_q  <= cpu_addr;
            wdata_q <= cpu_wdata;
            cs_n_q  <= cs_decode(cpu_cs_sel);
         end
         if (state_q == S_RDY && cycle_end && !write_q) begin
            cpu_rdata_q <= bus_data_i;
         end
         if (state_d == S_IDLE || state_d == S_HOLD) begin
            cs_n_q <= {NCS{1'b1}};
         end
      end
   end

   // ==========================================================
   // pin drive
   assign driving  = (state_q != S_HOLD);
   assign cmd_on   = (state_q == S_CMD) || (state_q == S_RDY);
   assign bus_addr_o            = addr_q;
   assign bus_addr_oe           = driving;
   assign ale_o                 = (state_q == S_ADDR);
   assign ale_oe                = driving;
   assign rd_n_o                = ~(cmd_on & ~write_q);
   assign wr_n_o                = ~(cmd_on & write_q);
   assign cmd_oe                = driving;
   assign bus_data_o            = wdata_q;
   assign bus_data_oe           = driving & write_q & (cmd_on | (state_q == S_DLY));
   assign chip_select_lines_n_o = cs_n_q;
   assign chip_select_lines_oe  = driving;
   assign system_clock_output   = clk_div_q;

   // acknowledge low only while the bus is given away
   assign bus_grant_ack_out_n = (state_q != S_HOLD);
   // regain only asked while released and still held
   assign bus_regain_request_out = (state_q == S_HOLD) & ~hold_q &
                 (ctrl_q[`EBRA_CTRL_REGAIN] | cpu_req);
   assign bus_regain_request_out_n = ~bus_regain_request_out;

   assign cpu_done  = done_q;
   assign cpu_rdata = cpu_rdata_q;

   // ==========================================================
   // register port
   assign stat_word = {{(32 - `EBRA_STAT_ST_LO - `EBRA_NST){1'b0}}, state_q,
                       4'h0, ~hold_q, bus_regain_request_out, (state_q != S_IDLE),
                       (state_q == S_HOLD)};

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q  <= `EBRA_CTRL_RST;
         rdata_q <= 32'h0000_0000;
      end else begin
         if (reg_wr && reg_addr == `EBRA_OFS_CTRL) begin
            ctrl_q <= reg_wdata[`EBRA_CTRL_W-1:0];
         end
         if (reg_rd) begin
            case (reg_addr)
               `EBRA_OFS_CTRL: begin
                  rdata_q <= {{(32 - `EBRA_CTRL_W){1'b0}}, ctrl_q};
               end
               `EBRA_OFS_STAT: begin
                  rdata_q <= stat_word;
               end
               `EBRA_OFS_RDATA: begin
                  rdata_q <= {{(32 - DW){1'b0}}, cpu_rdata_q};
               end
               default: begin
                  rdata_q <= 32'h0000_0000;
               end
            endcase
         end else begin
            rdata_q <= 32'h0000_0000;
         end
      end
   end

   assign reg_rdata = rdata_q;
endmodule

// ==== test/ebra_props.sv ====
/*
 checker for the bus cycle and hold arbitration pins of the core.
 assumes binding to ebra_core; sees only its ports.
*/
`timescale 1ns/100ps
module ebra_props (
   input wire sys_clk,
   input wire resetn,
   input wire hold_n,
   input wire rd_n_o,
   input wire wr_n_o,
   input wire ale_o,
   input wire cmd_oe,
   input wire bus_addr_oe,
   input wire chip_select_lines_oe,
   input wire cpu_done,
   input wire bus_grant_ack_out_n,
   input wire bus_regain_request_out_n
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // ==========================
   // arbitration checks
   a_release_float: assert property (
      !bus_grant_ack_out_n |-> !chip_select_lines_oe && !bus_addr_oe && !cmd_oe)
      else $error("bus driven while granted");
   a_regain_gated: assert property (
      !bus_regain_request_out_n |-> !bus_grant_ack_out_n)
      else $error("regain request before release");
   a_grant_sync: assert property (
      $fell(bus_grant_ack_out_n) |-> !$past(hold_n, 2))
      else $error("grant without sampled hold");
   a_regain_on_hold: assert property (
      $rose(bus_grant_ack_out_n) |-> $past(hold_n, 2))
      else $error("bus taken back while hold low");
   a_hold_keeps: assert property (
      !bus_grant_ack_out_n && !hold_n && !$past(hold_n) |=> !bus_grant_ack_out_n)
      else $error("grant dropped while hold low");
   a_grant_idle: assert property (
      $fell(bus_grant_ack_out_n) |-> $past(rd_n_o) && $past(wr_n_o) && !$past(ale_o))
      else $error("grant in mid cycle");
   a_regain_drive: assert property (
      $rose(bus_grant_ack_out_n) |-> chip_select_lines_oe && bus_addr_oe)
      else $error("bus not driven after regain");
   // ==========================
   // cycle end check
   a_done_after_cmd: assert property (
      cpu_done |-> !$past(rd_n_o) || !$past(wr_n_o))
      else $error("cycle ended without command");
   cover property ($fell(bus_grant_ack_out_n));
   cover property ($fell(bus_regain_request_out_n));
   cover property (cpu_done);
endmodule
bind ebra_core ebra_props ebra_props_i (.*);

// ==== test/ebra_far.sv ====
/*
 far side: a memory that answers ready after a set delay, and an outside
 master whose hold request follows a bench signal.
 assumes active-low command strobes from the core.
*/
`timescale 1ns/100ps
module ebra_far (
   input  wire        sys_clk,
   input  wire        resetn,
   input  wire        rd_n_o,
   input  wire        wr_n_o,
   input  wire [3:0]  slow,
   input  wire [15:0] rdata,
   input  wire        hold_req,
   output reg         ready_n,
   output reg  [15:0] bus_data_i,
   output reg         hold_n
);
   reg [3:0] cnt_q;
   // ==========================
   // ready, read data and hold
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q      <= 4'h0;
         ready_n    <= 1'b1;
         bus_data_i <= 16'h0000;
         hold_n     <= 1'b1;
      end else begin
         hold_n <= !hold_req; // may drop unasked
         if (rd_n_o && wr_n_o) begin
            cnt_q      <= 4'h0;
            ready_n    <= 1'b1; // withdrawn after the command
            bus_data_i <= ~bus_data_i; // released bus keeps changing
         end else begin
            cnt_q   <= (cnt_q == 4'hf) ? cnt_q : cnt_q + 4'h1;
            ready_n <= (cnt_q < slow); // high while cnt_q is below slow, then low until the command rises
            if (!rd_n_o)
               bus_data_i <= rdata;
         end
      end
   end
endmodule

// ==== test/tb_top.sv ====
/*
 testbench: register port, read cycles under wait settings, hold arbitration.
 assumes ebra_core, ebra_far and the bound checker are compiled.
*/
`timescale 1ns/100ps
module tb_top;
   reg         sys_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   reg         cpu_req = 1'b0, cpu_write = 1'b0, hold_req = 1'b0;
   reg  [3:0]  reg_addr = 4'h0, slow = 4'h0;
   reg  [31:0] reg_wdata = 32'h0000_0000;
   reg  [23:0] cpu_addr = 24'h00_1234;
   reg  [2:0]  cpu_cs_sel = 3'h1;
   reg  [15:0] cpu_wdata = 16'h0000, rdata = 16'h5a3c;
   wire [31:0] reg_rdata;
   wire [15:0] cpu_rdata, bus_data_i, bus_data_o;
   wire [23:0] bus_addr_o;
   wire [4:0]  chip_select_lines_n_o;
   wire        cpu_done, system_clock_output, bus_addr_oe, bus_data_oe, ale_o, ale_oe;
   wire        rd_n_o, wr_n_o, cmd_oe, chip_select_lines_oe, ready_n, hold_n;
   wire        bus_grant_ack_out_n, bus_regain_request_out_n;
   integer     err_total = 0, checked = 0, cyc = 0, i, lat, gap, g0, l0, tmp;
   reg  [9:0]  c;
   localparam [59:0] CFG = {10'h003, 10'h001, 10'h0f4, 10'h030, 10'h004, 10'h000};
   ebra_core ebra_core_i (.*);
   ebra_far ebra_far_i (.*);
   always #2 sys_clk = ~sys_clk;
   // ==========================
   // checks and closing
   task cmp(input [31:0] got, input [31:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task end_of_test;
      begin
         $display("checked %0d err_total %0d", checked, err_total);
         if (err_total == 0 && checked > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   always @(posedge sys_clk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         err_total = err_total + 1;
         end_of_test;
      end
   end
   // ==========================
   // register port and bus tasks
   task wr(input [3:0] a, input [31:0] d);
      begin
         @(posedge sys_clk);
         reg_addr  <= a;
         reg_wdata <= d;
         reg_wr    <= 1'b1;
         @(posedge sys_clk);
         reg_wr <= 1'b0;
      end
   endtask
   task rd(input [3:0] a, input [31:0] e);
      begin
         @(posedge sys_clk);
         reg_addr <= a;
         reg_rd   <= 1'b1;
         @(posedge sys_clk);
         reg_rd <= 1'b0;
         #1 cmp(reg_rdata, e);
      end
   endtask
   task wait_done(output integer n);
      begin
         n = 0;
         while (cpu_done !== 1'b1 && n < 99) begin
            @(posedge sys_clk);
            #1 n = n + 1;
         end
      end
   endtask
   task wait_ack(input v);
      integer n;
      begin
         n = 0;
         while (bus_grant_ack_out_n !== v && n < 99) begin
            @(posedge sys_clk);
            #1 n = n + 1;
         end
         cmp(bus_grant_ack_out_n, v);
      end
   endtask
   // two reads back to back: latency of the first, gap to the next address
   task run(input [9:0] cv, input [3:0] s);
      begin
         wr(4'h0, {{22{1'b0}}, cv});
         slow    <= s;
         cpu_req <= 1'b1;
         wait_done(lat);
         gap = 0;
         while (ale_o !== 1'b1 && gap < 99) begin
            @(posedge sys_clk);
            #1 gap = gap + 1;
         end
         @(posedge sys_clk);
         cpu_req <= 1'b0;
         wait_done(tmp);
         repeat (4) @(posedge sys_clk);
      end
   endtask
   // ==========================
   // main sequence
   initial begin
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      rd(4'h0, 32'h0000_0000);
      wr(4'h4, 32'h0000_03ff);
      rd(4'h4, 32'h0000_0100);
      rd(4'hc, 32'h0000_0000);
      for (i = 0; i < 6; i = i + 1) begin
         c = CFG[i*10 +: 10];
         run(c, 4'h0);
         if (i == 0)
            g0 = gap;
         cmp(lat, 4 + c[2] + c[7:4]);
         cmp(gap - g0, c[0] + c[1]);
         cmp(cpu_rdata, rdata);
      end
      run(10'h008, 4'h0);
      l0 = lat;
      run(10'h008, 4'h6);
      cmp(lat - l0, 6);
      cmp(cpu_rdata, rdata);
      // write cycle on chip select 1 with the clock output running
      wr(4'h0, 32'h0000_0200);
      cpu_write <= 1'b1;
      cpu_wdata <= 16'hc3a5;
      cpu_req   <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1 cmp({wr_n_o, rd_n_o, bus_data_oe}, 3'h3);
      cmp(bus_data_o, 16'hc3a5);
      cmp({chip_select_lines_n_o, bus_addr_o}, {5'h1d, 24'h00_1234});
      tmp = system_clock_output;
      @(posedge sys_clk);
      #1 cmp(system_clock_output, !tmp);
      @(posedge sys_clk);
      cpu_req   <= 1'b0;
      cpu_write <= 1'b0;
      #1 cmp(cpu_done, 1'b1);
      cmp(cpu_rdata, rdata);
      // hold arrives in mid cycle, regain with a pending request
      wr(4'h0, 32'h0000_0008);
      slow    <= 4'ha;
      cpu_req <= 1'b1;
      repeat (4) @(posedge sys_clk);
      hold_req <= 1'b1;
      wait_done(lat);
      cmp(bus_grant_ack_out_n, 1'b1);
      @(posedge sys_clk);
      cpu_req <= 1'b0;
      wait_ack(1'b0);
      cmp({chip_select_lines_oe, ale_oe, bus_data_oe, cmd_oe}, 4'h0);
      cmp(chip_select_lines_n_o, 5'h1f);
      cmp(bus_regain_request_out_n, 1'b1);
      @(posedge sys_clk);
      cpu_req <= 1'b1;
      repeat (8) @(posedge sys_clk);
      #1 cmp(bus_regain_request_out_n, 1'b0);
      cmp(bus_grant_ack_out_n, 1'b0);
      @(posedge sys_clk);
      hold_req <= 1'b0;
      wait_ack(1'b1);
      // request taken two edges after the regain state shows
      repeat (2) @(posedge sys_clk);
      cpu_req <= 1'b0;
      wait_done(lat);
      cmp(cpu_done, 1'b1);
      @(posedge sys_clk);
      hold_req <= 1'b1;
      wait_ack(1'b0);
      wr(4'h0, 32'h0000_0100);
      rd(4'h4, 32'h0000_800f);
      wr(4'h0, 32'h0000_0000);
      rd(4'h4, 32'h0000_800b);
      @(posedge sys_clk);
      hold_req <= 1'b0;
      wait_ack(1'b1);
      end_of_test;
   end
endmodule
